// ### design/scp_pkg.sv
/*
 * Package for the selective paging control block: timing constants,
 * code widths, display modes and the packed carriers shared by the
 * main module and its code matcher.
 * Assumes a single 10 MHz clock; no software-visible registers.
 */
package scp_pkg;

    localparam int  CLK_HZ        = 10_000_000;
    localparam int  HOLD_MS       = 500;
    localparam int  HOLD_CYCLES   = (CLK_HZ / 1000) * HOLD_MS;
    localparam int  DIGITS        = 4;
    localparam int  TX_SLOTS      = 5;
    localparam int  SLOT_W        = 3;
    localparam int  DIGIT_W       = 4;
    localparam int  CODE_W        = DIGITS * DIGIT_W;
    localparam logic [3:0] WILD_DIGIT  = 4'h0;
    localparam logic [3:0] HYPHEN_DIGIT = 4'hf;
    localparam logic [CODE_W-1:0] BLANK_CODE = 16'hffff;
    localparam logic [2:0] RX_SLOT  = 3'h0;
    localparam logic [2:0] LAST_SLOT = 3'h5;

    typedef logic [CODE_W-1:0] scp_code_type;

    typedef enum logic [2:0] {
        SCP_NORMAL   = 3'b000,
        SCP_BROWSE   = 3'b001,
        SCP_ENTRY    = 3'b010,
        SCP_LISTEN   = 3'b011,
        SCP_SETUP    = 3'b100,
        SCP_HALTED   = 3'b101
    } scp_state_type;

    typedef struct packed {
        logic       pagingKey;
        logic       entryKey;
        logic       dialCw;
        logic       dialCcw;
        logic       digitValid;
        logic [3:0] digit;
    } scp_keys_type;

    typedef struct packed {
        logic        valid;
        scp_code_type code;
    } scp_page_type;

endpackage

// ### design/scp_matcher.sv
/*
 * Code matcher: compares a received page against the stored receive
 * identity code, digit by digit, with zero in the page as wildcard.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
module scp_matcher
    import scp_pkg::*;
(
    // codes
    input  wire scp_code_type pageCode,
    input  wire scp_code_type ownCode,
    // result
    output logic              hit
);
    logic [DIGITS-1:0] digitOk;

    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : gDigit
            assign digitOk[g] = (pageCode[g*DIGIT_W +: DIGIT_W] == WILD_DIGIT) ||
                                (pageCode[g*DIGIT_W +: DIGIT_W] ==
                                 ownCode[g*DIGIT_W +: DIGIT_W]);
        end
    endgenerate

    // all-zero page passes every digit by the wildcard, so it reaches all
    assign hit = &digitOk;
endmodule
`default_nettype wire

// ### design/scp_control.sv
/*
 * Selective paging control: stores one receive identity code and five
 * transmit page codes, decodes short and held presses of the paging and
 * entry keys, sends pages and listens for matching pages.
 * Assumes debounced keys, one-cycle dial/digit pulses, clk at 10 MHz.
 * A power cycle is reset_n plus powerUp; codes survive only in flops.
 */
// How it works
// - held paging key on tx code sends page
// - short press then hold repeats the page
// - held key on rx code re-enters listening
// - key held at power-up opens setup
// - entry short starts, held commits four digits
// - zero digit refused in receive code
// - five tx slots, dial steps through them
// - zero in page matches any digit
// - all-zero page reaches every listening station with an rx code stored
// - tx editable while browsing, rx only in setup
// - after setup, halt until a short paging press
// - listening mutes receiver, match rings alarm
`timescale 1ns/1ps
`default_nettype none
module scp_control
    import scp_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES
)(
    // clock, reset, enable
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         clkEn,
    // power-on strobe, one pulse after power is applied
    input  wire logic         powerUp,
    // operator controls
    input  wire scp_keys_type keys,
    // received page from the demodulator
    input  wire scp_page_type rxPage,
    // transmitter side
    output logic              txKey,
    output logic              txPageValid,
    output scp_code_type      txPageCode,
    // receiver and annunciators
    output logic              rxMute,
    output logic              alarmBell,
    output logic              pagingBlink,
    output logic              pagingIcon,
    // display
    output scp_code_type      showCode,
    output logic [SLOT_W-1:0] showSlot,
    output logic [DIGITS-1:0] blinkDigit,
    output logic              showFrequency
);
    localparam int CNT_W = $clog2(HOLD_COUNT + 1);

    scp_state_type      state_reg, state_next;
    scp_code_type       codes_reg [TX_SLOTS+1];
    logic               rxStored_reg;
    logic [SLOT_W-1:0]  slot_reg, slot_next;
    scp_code_type       work_reg;
    logic [2:0]         digitPos_reg;
    logic               setupSeen_reg;
    logic [CNT_W-1:0]   pagCnt_reg, entCnt_reg;
    logic               pagPrev_reg, entPrev_reg;
    logic               pagLong_reg, entLong_reg;
    logic               alarm_reg;

    // press classification: release before hold is short, reaching hold is long
    wire pagRelease  = pagPrev_reg && !keys.pagingKey;
    wire entRelease  = entPrev_reg && !keys.entryKey;
    wire pagHoldHit  = keys.pagingKey && !pagLong_reg && (pagCnt_reg == CNT_W'(HOLD_COUNT - 1));
    wire entHoldHit  = keys.entryKey && !entLong_reg && (entCnt_reg == CNT_W'(HOLD_COUNT - 1));
    wire pagShort    = pagRelease && !pagLong_reg;
    wire entShort    = entRelease && !entLong_reg;

    wire onRx        = (slot_reg == RX_SLOT);
    wire digitOk     = keys.digitValid && !(onRx && keys.digit == WILD_DIGIT);
    wire entryFull   = (digitPos_reg == 3'(DIGITS));
    // rx code only editable from setup
    wire editAllowed = !onRx || setupSeen_reg;
    wire matchHit;
    wire pageMatch   = (state_reg == SCP_LISTEN) && rxPage.valid && rxStored_reg && matchHit;

    // an unstored rx code is blank, so pageMatch also gates on rxStored_reg
    scp_matcher uMatch (
        .pageCode (rxPage.code),
        .ownCode  (codes_reg[RX_SLOT]),
        .hit      (matchHit)
    );

    // dial steps slots while browsing; clockwise from rx reaches tx 1
    always_comb begin
        slot_next = slot_reg;
        if (keys.dialCw && slot_reg != LAST_SLOT)
            slot_next = slot_reg + 3'h1;
        else if (keys.dialCcw && slot_reg != RX_SLOT)
            slot_next = slot_reg - 3'h1;
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SCP_NORMAL: begin
                if (pagShort)
                    state_next = SCP_BROWSE;
            end
            SCP_BROWSE: begin
                if (entShort && editAllowed)
                    state_next = SCP_ENTRY;
                else if (pagHoldHit && onRx)
                    state_next = SCP_LISTEN;
            end
            SCP_SETUP: begin
                if (entShort)
                    state_next = SCP_ENTRY;
            end
            SCP_ENTRY: begin
                // commit goes back to the frequency; setup ends in halt
                if (entHoldHit && entryFull)
                    state_next = setupSeen_reg ? SCP_HALTED : SCP_NORMAL;
            end
            SCP_LISTEN: begin
                if (pagShort)
                    state_next = SCP_BROWSE;
            end
            SCP_HALTED: begin
                // dial browsing; a short paging press returns to browsing, where pages and listening work again
                if (pagShort)
                    state_next = SCP_BROWSE;
            end
            default: state_next = SCP_NORMAL;
        endcase
        if (powerUp && keys.pagingKey)
            state_next = SCP_SETUP;
    end

    // counters clear and hold at zero once a press turns long, so a long press never wraps
    wire pagCounting = keys.pagingKey && !pagLong_reg;
    wire entCounting = keys.entryKey && !entLong_reg;

    // a release after the hold edge is swallowed by the long latch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pagCnt_reg  <= '0;
            pagPrev_reg <= 1'b0;
            pagLong_reg <= 1'b0;
        end else if (clkEn) begin
            pagPrev_reg <= keys.pagingKey;
            pagCnt_reg  <= pagCounting ? pagCnt_reg + CNT_W'(1) : '0;
            pagLong_reg <= keys.pagingKey && (pagLong_reg || pagHoldHit);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            entCnt_reg  <= '0;
            entPrev_reg <= 1'b0;
            entLong_reg <= 1'b0;
        end else if (clkEn) begin
            entPrev_reg <= keys.entryKey;
            entCnt_reg  <= entCounting ? entCnt_reg + CNT_W'(1) : '0;
            entLong_reg <= keys.entryKey && (entLong_reg || entHoldHit);
        end
    end

    // only the browsing states follow the dial; the rest park on the rx code
    // entry keeps the slot that it started on
    wire dialFree    = (state_reg == SCP_BROWSE) || (state_reg == SCP_HALTED);
    wire slotPark    = (state_reg == SCP_NORMAL) || (state_reg == SCP_LISTEN) || (state_reg == SCP_SETUP);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= SCP_NORMAL;
            slot_reg  <= RX_SLOT;
        end else if (clkEn) begin
            state_reg <= state_next;
            if (dialFree)
                slot_reg <= slot_next;
            else if (slotPark)
                slot_reg <= RX_SLOT;
        end
    end

    // setup session remembered until the next power cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            setupSeen_reg <= 1'b0;
        else if (clkEn && powerUp)
            setupSeen_reg <= keys.pagingKey;
    end

    // code store and digit entry
    // commit only with four digits in; an early hold is ignored
    wire entryStart  = (state_reg != SCP_ENTRY) && (state_next == SCP_ENTRY);
    wire digitTake   = (state_reg == SCP_ENTRY) && digitOk && !entryFull;
    wire commitNow   = (state_reg == SCP_ENTRY) && entHoldHit && entryFull;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            work_reg     <= BLANK_CODE;
            digitPos_reg <= '0;
        end else if (clkEn) begin
            if (entryStart) begin
                work_reg     <= codes_reg[slot_reg];
                digitPos_reg <= '0;
            end else if (digitTake) begin
                // digits shift in from the right, the first keyed ends leftmost
                work_reg     <= {work_reg[CODE_W-DIGIT_W-1:0], keys.digit};
                digitPos_reg <= digitPos_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i <= TX_SLOTS; i++)
                codes_reg[i] <= BLANK_CODE;
            rxStored_reg <= 1'b0;
        end else if (clkEn) begin
            if (commitNow)
                codes_reg[slot_reg] <= work_reg;
            if (commitNow && onRx)
                rxStored_reg <= 1'b1;
        end
    end

    // page goes out on the hold edge only while a tx slot is shown
    wire sendNow     = pagHoldHit && (state_reg == SCP_BROWSE) && !onRx;
    // transmitter stays keyed only while the operator keeps the key down
    wire txKeyNext   = sendNow || (txKey && keys.pagingKey);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txKey       <= 1'b0;
            txPageValid <= 1'b0;
            txPageCode  <= '0;
        end else if (clkEn) begin
            txKey       <= txKeyNext;
            txPageValid <= sendNow;
            if (sendNow)
                txPageCode <= codes_reg[slot_reg];
        end
    end

    // bell and blink gated by listening, so they never outlive the icon
    // trade-off: a ringing alarm unmutes the receiver so the call is heard
    wire listenNext  = (state_next == SCP_LISTEN);
    wire ringNext    = (pageMatch || alarm_reg) && listenNext;
    wire muteNext    = listenNext && !ringNext;

    // a match on the leave edge still sets; the flag drops one cycle later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            alarm_reg <= 1'b0;
        else if (clkEn && pageMatch)
            alarm_reg <= 1'b1;
        else if (clkEn && !listenNext)
            alarm_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxMute      <= 1'b0;
            alarmBell   <= 1'b0;
            pagingBlink <= 1'b0;
            pagingIcon  <= 1'b0;
        end else if (clkEn) begin
            rxMute      <= muteNext;
            alarmBell   <= ringNext;
            pagingBlink <= ringNext;
            pagingIcon  <= listenNext;
        end
    end

    // display follows the slot, or the work code while digits go in
    wire               editShown = (state_reg == SCP_ENTRY);
    wire               freqNext  = (state_next == SCP_NORMAL) || listenNext;
    scp_code_type      showNext;
    logic [DIGITS-1:0] blinkNext;

    assign showNext  = editShown ? work_reg : codes_reg[slot_reg];
    assign blinkNext = (editShown && !entryFull) ? DIGITS'(4'h8 >> digitPos_reg) : '0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            showCode      <= BLANK_CODE;
            showSlot      <= RX_SLOT;
            blinkDigit    <= '0;
            showFrequency <= 1'b1;
        end else if (clkEn) begin
            showCode      <= showNext;
            showSlot      <= slot_reg;
            blinkDigit    <= blinkNext;
            showFrequency <= freqNext;
        end
    end
endmodule
`default_nettype wire

// ### verification/scp_checker.sv
/* port checker for scp_control: page timing, listening, display
   bound from the bench top; one clock, async active-low reset */
`timescale 1ns/1ps
`default_nettype none
module scp_checker
    import scp_pkg::*;
#(
    parameter int HOLD_COUNT = 8
)(
    // clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              clkEn,
    // operator and station side
    input wire scp_keys_type      keys,
    input wire scp_page_type      rxPage,
    // transmitter and receiver
    input wire logic              txKey,
    input wire logic              txPageValid,
    input wire logic              rxMute,
    input wire logic              alarmBell,
    input wire logic              pagingBlink,
    input wire logic              pagingIcon,
    // display
    input wire scp_code_type      showCode,
    input wire logic [SLOT_W-1:0] showSlot,
    input wire logic [DIGITS-1:0] blinkDigit,
    input wire logic              showFrequency
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    int heldCnt_reg;
    // a blank display digit is f, so only a real zero trips this
    wire zeroDigit = showCode[15:12] == 4'h0 || showCode[11:8] == 4'h0 ||
                     showCode[7:4] == 4'h0 || showCode[3:0] == 4'h0;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) heldCnt_reg <= 0;
        else if (clkEn) heldCnt_reg <= keys.pagingKey ? heldCnt_reg + 1 : 0;
    end
    send_hold_a: assert property ($rose(txPageValid) |-> heldCnt_reg == HOLD_COUNT)
        else $error("page sent without a full hold");
    page_pulse_a: assert property (txPageValid |=> !txPageValid)
        else $error("page strobe longer than one cycle");
    key_with_page_a: assert property (txPageValid |-> txKey)
        else $error("page sent with transmitter unkeyed");
    key_release_a: assert property (clkEn && !keys.pagingKey |=> !txKey)
        else $error("transmitter keyed after key release");
    slot_limit_a: assert property (showSlot <= LAST_SLOT)
        else $error("slot beyond last transmit code");
    alarm_state_a: assert property (alarmBell |-> pagingBlink && !rxMute && pagingIcon)
        else $error("alarm without blink or unmute");
    alarm_cause_a: assert property ($rose(alarmBell) |-> $past(rxPage.valid))
        else $error("alarm without a received page");
    listen_mute_a: assert property (pagingIcon && !alarmBell |-> rxMute)
        else $error("listening but receiver not muted");
    rx_nonzero_a: assert property (showSlot == RX_SLOT && blinkDigit == 4'h0 && !showFrequency |-> !zeroDigit)
        else $error("zero digit in receive code");
    cover property ($rose(txPageValid));
    cover property ($rose(alarmBell));
    cover property ($rose(pagingIcon));
endmodule
`default_nettype wire

// ### verification/scp_station.sv
/* remote station: sends one page to the receiver on request
   drives on the falling edge, like the bench */
`timescale 1ns/1ps
`default_nettype none
module scp_station
    import scp_pkg::*;
(
    // clock
    input wire logic       clk,
    // page to the receiver
    output var scp_page_type rxPage
);
    initial rxPage = '{valid: 1'b0, code: 16'h5a5a};
    task automatic send(input scp_code_type c);
        @(negedge clk);
        rxPage <= '{valid: 1'b1, code: c};
        @(negedge clk);
        // code is not held after the strobe
        rxPage <= '{valid: 1'b0, code: ~c};
    endtask
endmodule
`default_nettype wire

// ### verification/scp_control_test.sv
/* bench for scp_control: setup entry, listening, transmit pages
   station model feeds pages; checker bound at the foot */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module scp_control_test;
    import scp_pkg::*;
    localparam int HC = 8;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              clkEn = 1'b1;
    logic              powerUp = 1'b0;
    scp_keys_type      keys = '0;
    scp_page_type      rxPage;
    logic              txKey, txPageValid, rxMute, alarmBell, pagingBlink, pagingIcon, showFrequency;
    scp_code_type      txPageCode, showCode;
    logic [SLOT_W-1:0] showSlot;
    logic [DIGITS-1:0] blinkDigit;
    logic              hit;
    int                n_mismatch = 0, n_compared = 0, cycles = 0, own = 'h1234, page, d;
    always #50 clk = ~clk;
    scp_control #(.HOLD_COUNT(HC)) uut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .powerUp(powerUp),
        .keys(keys), .rxPage(rxPage), .txKey(txKey), .txPageValid(txPageValid), .txPageCode(txPageCode),
        .rxMute(rxMute), .alarmBell(alarmBell), .pagingBlink(pagingBlink), .pagingIcon(pagingIcon),
        .showCode(showCode), .showSlot(showSlot), .blinkDigit(blinkDigit), .showFrequency(showFrequency));
    scp_station st (.clk(clk), .rxPage(rxPage));
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ent picks the entry key; n held cycles, HC+1 is a long press
    task automatic key(input bit ent, input int n);
        if (ent) keys.entryKey = 1'b1;
        else keys.pagingKey = 1'b1;
        tick(n);
        keys.entryKey = 1'b0;
        keys.pagingKey = 1'b0;
        tick(2);
    endtask
    task automatic dig(input logic [3:0] v);
        keys.digit = v;
        keys.digitValid = 1'b1;
        tick(1);
        keys.digitValid = 1'b0;
        tick(1);
    endtask
    task automatic dial(input int n);
        repeat (n < 0 ? -n : n) begin
            keys.dialCw = n > 0;
            keys.dialCcw = n < 0;
            tick(1);
            keys.dialCw = 1'b0;
            keys.dialCcw = 1'b0;
            tick(1);
        end
    endtask
    function automatic bit hit_of(input int p, input int o);
        hit_of = 1;
        for (int i = 0; i < 16; i += 4)
            if (((p >> i) & 15) != 0 && ((p >> i) & 15) != ((o >> i) & 15)) hit_of = 0;
    endfunction
    task automatic send_chk(input scp_code_type e);
        keys.pagingKey = 1'b1;
        tick(HC);
        for (int i = 0; i < 4 && txPageValid !== 1'b1; i++) tick(1);
        `CHK(txPageValid, 1'b1)
        `CHK(txPageCode, e)
        `CHK(txKey, 1'b1)
        keys.pagingKey = 1'b0;
        tick(2);
        `CHK(txKey, 1'b0)
    endtask
    task automatic end_of_test;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'h35ec));
        tick(3);
        reset_n = 1'b1;
        keys.pagingKey = 1'b1;
        powerUp = 1'b1;
        tick(1);
        keys.pagingKey = 1'b0;
        powerUp = 1'b0;
        tick(2);
        `CHK(showCode, BLANK_CODE)
        key(1, 2);
        key(1, HC + 1);
        `CHK(blinkDigit, 4'b1000)
        dig(0); dig(1); dig(2); dig(3); dig(4); dig(5);
        key(1, HC + 1);
        `CHK(showFrequency, 1'b0)
        key(0, 2);
        `CHK(showCode, 16'h1234)
        key(0, HC + 1);
        `CHK(rxMute, 1'b1)
        st.send(16'h0000);
        `CHK(alarmBell, 1'b1)
        for (int n = 0; n < 15; n++) begin
            key(0, 2);
            key(0, HC + 1);
            page = 0;
            for (int i = 0; i < 16; i += 4) begin
                d = $urandom % 3;
                page |= (d == 0 ? 0 : d == 1 ? (own >> i) & 15 : $urandom_range(9, 1)) << i;
            end
            st.send(16'(page));
            tick(1);
            hit = hit_of(page, own);
            `CHK(alarmBell, hit)
            `CHK(rxMute, ~hit)
            `CHK(pagingBlink, hit)
        end
        reset_n = 1'b0;
        tick(1);
        reset_n = 1'b1;
        powerUp = 1'b1;
        tick(1);
        powerUp = 1'b0;
        tick(2);
        `CHK(showFrequency, 1'b1)
        key(0, 2);
        dial(6);
        `CHK(showSlot, 3'h5)
        dial(-4);
        key(1, 2);
        dig(0); dig(5); dig(5); dig(5);
        key(1, HC + 1);
        key(0, 2);
        dial(1);
        `CHK(showCode, 16'h0555)
        send_chk(16'h0555);
        key(0, 2);
        send_chk(16'h0555);
        dial(-1);
        key(1, 2);
        dig(9); dig(9); dig(9); dig(9);
        key(1, HC + 1);
        `CHK(showCode, BLANK_CODE)
        clkEn = 1'b0;
        key(0, HC + 2);
        clkEn = 1'b1;
        `CHK(pagingIcon, 1'b0)
        key(0, HC + 1);
        `CHK(pagingIcon, 1'b1)
        end_of_test();
    end
endmodule
bind scp_control scp_checker #(.HOLD_COUNT(HOLD_COUNT)) chk (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .keys(keys), .rxPage(rxPage), .txKey(txKey), .txPageValid(txPageValid), .rxMute(rxMute),
    .alarmBell(alarmBell), .pagingBlink(pagingBlink), .pagingIcon(pagingIcon), .showCode(showCode),
    .showSlot(showSlot), .blinkDigit(blinkDigit), .showFrequency(showFrequency));
`default_nettype wire
